/* odl_regs.svh */
`ifndef ODL_REGS_SVH
`define ODL_REGS_SVH
`define ODL_FRAME_BITS      32
`define ODL_CNT_W           6
`define ODL_CHANNELS        8
`define ODL_CODE_W          16
`define ODL_CMD_POS         24
`define ODL_CMD_W           4
`define ODL_ADDR_POS        20
`define ODL_ADDR_W          4
`define ODL_DATA_POS        4
`define ODL_CODE_ZERO       16'h0000
`define ODL_CODE_MID        16'h8000
`define ODL_CODE_FULL       16'hFFFF
`define ODL_CLRSEL_RESET    2'h0
`define ODL_FIFO_DEPTH      8
`define ODL_FIFO_AW         3
`define ODL_CMD_WRITE_IN    4'h0
`define ODL_CMD_UPD_ONE     4'h1
`define ODL_CMD_WRITE_UPD   4'h3
`define ODL_CMD_CLR_CODE    4'h5
`define ODL_CMD_REF_SETUP   4'h8
`define ODL_ADDR_ALL        4'hF
`define ODL_SCLK_MAX_MHZ    50
`endif

/* odl_pkg.sv */
package odl_pkg;
	typedef enum logic [1:0] {
		ODL_CLR_ZERO,
		ODL_CLR_MID,
		ODL_CLR_FULL,
		ODL_CLR_NONE
	} odl_clr_sel_type;
	typedef logic [15:0] odl_code_type;
endpackage

/* odl_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module odl_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic [AW:0]      cnt_r;
	wire              push = wr_valid_i && wr_ready_o;
	wire              pop  = rd_valid_o && rd_ready_i;
	wire  [AW:0]      cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	wire  [AW:0]      rp_nxt = rp_r + {{AW{1'b0}}, pop};
	// Read data registered: next head loaded on pop or when data first lands
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wp_r       <= '0;
			rp_r       <= '0;
			cnt_r      <= '0;
			wr_ready_o <= 1'b1;
			rd_valid_o <= 1'b0;
		end else begin
			wp_r       <= wp_r + {{AW{1'b0}}, push};
			rp_r       <= rp_nxt;
			cnt_r      <= cnt_nxt;
			wr_ready_o <= (cnt_nxt < (AW+1)'(DEPTH));
			rd_valid_o <= (cnt_nxt != '0);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (push)
			mem_r[wp_r[AW-1:0]] <= wr_data_i;
		rd_data_o <= (push && (cnt_r == rp_nxt - rp_r)) ? wr_data_i : mem_r[rp_nxt[AW-1:0]];
	end
endmodule // odl_fifo
`default_nettype wire

/* odl_core.sv */
// Operation
// - On load strobe low, DAC registers take input registers that hold new data.
// - All affected channels update together on the same clock edge.
// - Frame select falling enables the shift register for a new frame.
// - One data bit captured on each falling shift clock edge, 32 per frame.
// - Frame select rising before bit 32 aborts, discarding the partial word.
// - Clear acts on its falling edge, independent of shift clock.
// - While clear is low, load strobe transfers are blocked.
// - Clear loads input and DAC registers with the clear code value.
// - Clear code setting resets to zero code.
// - Input shift register is 32 bits, shifted on falling shift clock edges.
// - Shift clock up to 50 MHz is accepted.
// - After reset the shared reference pin is an input, external reference.
`timescale 1ns/10ps
`default_nettype none
`include "odl_regs.svh"
module odl_core (
	input  wire logic                  clk_sys_i,
	input  wire logic                  resetn_i,
	input  wire logic                  sclk_i,
	input  wire logic                  frame_sel_n_i,
	input  wire logic                  sdata_i,
	input  wire logic                  load_strobe_n_i,
	input  wire logic                  async_clear_n_i,
	output logic [8*16-1:0]            dac_code_o,
	output logic [7:0]                 dac_update_o,
	output logic                       int_ref_en_o,
	output logic                       shared_ref_pin_oe_o,
	output odl_pkg::odl_clr_sel_type   clear_sel_o,
	output logic                       frame_drop_o
);
	import odl_pkg::*;

	// ------------------------------------------------------------
	// Link side, shift clock domain
	// ------------------------------------------------------------
	// Frame select acts as async reset of the shifter, so a rising edge
	// aborts mid-frame without needing a shift clock edge.
	logic [31:0]             shift_r;
	logic [`ODL_CNT_W-1:0]   bit_cnt_r;
	logic [31:0]             word_r;
	logic                    word_tgl_r;
	wire                     frame_done = (bit_cnt_r == `ODL_CNT_W'(`ODL_FRAME_BITS));
	wire                     last_bit   = (bit_cnt_r == `ODL_CNT_W'(`ODL_FRAME_BITS - 1));
	wire  [31:0]             shift_nxt  = {shift_r[30:0], sdata_i};
	// System reset also clears the shifter, which may never see a select edge
	wire                     link_rst   = frame_sel_n_i || !resetn_i;
	wire                     take_word  = !frame_sel_n_i && last_bit;

	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst)
			bit_cnt_r <= '0;
		else if (!frame_done)
			bit_cnt_r <= bit_cnt_r + `ODL_CNT_W'(1);
	end

	always_ff @(negedge sclk_i or posedge link_rst) begin
		if (link_rst)
			shift_r <= '0;
		else if (!frame_done)
			shift_r <= shift_nxt;
	end

	// Word handoff on the 32nd edge only; held stable until toggle is seen
	always_ff @(negedge sclk_i or negedge resetn_i) begin
		if (!resetn_i)
			word_r <= '0;
		else if (take_word)
			word_r <= shift_nxt;
	end

	always_ff @(negedge sclk_i or negedge resetn_i) begin
		if (!resetn_i)
			word_tgl_r <= 1'b0;
		else if (take_word)
			word_tgl_r <= ~word_tgl_r;
	end

	// ------------------------------------------------------------
	// Crossing into system clock
	// ------------------------------------------------------------
	logic [2:0] tgl_sync_r;
	logic [1:0] load_sync_r;
	logic [1:0] clr_sync_r;
	logic       clr_d_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			tgl_sync_r <= '0;
		else
			tgl_sync_r <= {tgl_sync_r[1:0], word_tgl_r};
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			load_sync_r <= 2'h3;
		else
			load_sync_r <= {load_sync_r[0], load_strobe_n_i};
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			clr_sync_r <= 2'h3;
		else
			clr_sync_r <= {clr_sync_r[0], async_clear_n_i};
	end

	// Edge reference starts high: a clear held low through reset still fires once
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			clr_d_r <= 1'b1;
		else
			clr_d_r <= clr_sync_r[1];
	end

	wire word_evt = tgl_sync_r[2] ^ tgl_sync_r[1];
	wire clr_fall = clr_d_r && !clr_sync_r[1];
	wire clr_low  = !clr_sync_r[1];
	wire load_low = !load_sync_r[1];

	// Word is stable in word_r by the time the toggle has crossed
	logic [31:0] cmd_word_r;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			cmd_word_r <= '0;
		else if (word_evt)
			cmd_word_r <= word_r;
	end

	// ------------------------------------------------------------
	// Command FIFO
	// ------------------------------------------------------------
	logic        cmd_pend_r;
	logic        fifo_wr_ready;
	logic        fifo_rd_valid;
	logic [31:0] fifo_rd_data;
	wire         fifo_rd_ready = !clr_low;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			cmd_pend_r <= 1'b0;
		else if (word_evt)
			cmd_pend_r <= 1'b1;
		else if (fifo_wr_ready)
			cmd_pend_r <= 1'b0;
	end

	odl_fifo #(
		.WIDTH (32),
		.DEPTH (`ODL_FIFO_DEPTH),
		.AW    (`ODL_FIFO_AW)
	) u_fifo (
		.clk_sys_i  (clk_sys_i),
		.resetn_i   (resetn_i),
		.wr_valid_i (cmd_pend_r),
		.wr_ready_o (fifo_wr_ready),
		.wr_data_i  (cmd_word_r),
		.rd_valid_o (fifo_rd_valid),
		.rd_ready_i (fifo_rd_ready),
		.rd_data_o  (fifo_rd_data)
	);

	// Word lost if a new frame lands while the previous is still waiting
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			frame_drop_o <= 1'b0;
		else
			frame_drop_o <= word_evt && cmd_pend_r && !fifo_wr_ready;
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire                       cmd_go   = fifo_rd_valid && fifo_rd_ready;
	wire [`ODL_CMD_W-1:0]      cmd_op   = fifo_rd_data[`ODL_CMD_POS +: `ODL_CMD_W];
	wire [`ODL_ADDR_W-1:0]     cmd_addr = fifo_rd_data[`ODL_ADDR_POS +: `ODL_ADDR_W];
	wire [15:0]                cmd_data = fifo_rd_data[`ODL_DATA_POS +: `ODL_CODE_W];
	wire                       op_wr    = cmd_go && (cmd_op == `ODL_CMD_WRITE_IN);
	wire                       op_upd   = cmd_go && (cmd_op == `ODL_CMD_UPD_ONE);
	wire                       op_wu    = cmd_go && (cmd_op == `ODL_CMD_WRITE_UPD);
	wire                       op_clrc  = cmd_go && (cmd_op == `ODL_CMD_CLR_CODE);
	wire                       op_ref   = cmd_go && (cmd_op == `ODL_CMD_REF_SETUP);
	wire                       all_ch   = (cmd_addr == `ODL_ADDR_ALL);
	wire                       load_xfer = load_low && !clr_low;

	// ------------------------------------------------------------
	// Clear code and reference control
	// ------------------------------------------------------------
	odl_clr_sel_type clr_sel_r;
	logic            ref_en_r;
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			clr_sel_r <= ODL_CLR_ZERO;
		else if (op_clrc)
			clr_sel_r <= odl_clr_sel_type'(fifo_rd_data[1:0]);
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			ref_en_r <= 1'b0;
		else if (op_ref)
			ref_en_r <= fifo_rd_data[0];
	end

	odl_code_type clr_code;
	always_comb begin
		case (clr_sel_r)
			ODL_CLR_ZERO: clr_code = `ODL_CODE_ZERO;
			ODL_CLR_MID:  clr_code = `ODL_CODE_MID;
			ODL_CLR_FULL: clr_code = `ODL_CODE_FULL;
			ODL_CLR_NONE: clr_code = `ODL_CODE_ZERO;
			default:      clr_code = `ODL_CODE_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// Channel registers
	// ------------------------------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < `ODL_CHANNELS; ch++) begin : g_ch
			logic [15:0] in_r;
			logic [15:0] dac_r;
			logic        new_r;
			logic        upd_r;
			wire         hit     = all_ch || (cmd_addr == `ODL_ADDR_W'(ch));
			wire         wr_in   = (op_wr || op_wu) && hit;
			wire         upd_sw  = (op_upd || op_wu) && hit;
			wire         upd_hw  = load_xfer && new_r;
			wire         upd_any = upd_hw || upd_sw;
			wire [15:0]  in_nxt  = wr_in ? cmd_data : in_r;
			// Data already moved to the DAC register is no longer new
			wire         new_nxt = (wr_in || new_r) && !upd_any;

			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i)
					in_r <= `ODL_CODE_ZERO;
				else if (clr_fall)
					in_r <= clr_code;
				else
					in_r <= in_nxt;
			end

			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i)
					dac_r <= `ODL_CODE_ZERO;
				else if (clr_fall)
					dac_r <= clr_code;
				else if (upd_any)
					dac_r <= in_nxt;
			end

			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i)
					new_r <= 1'b0;
				else if (clr_fall)
					new_r <= 1'b0;
				else
					new_r <= new_nxt;
			end

			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i)
					upd_r <= 1'b0;
				else if (clr_fall)
					upd_r <= 1'b1;
				else
					upd_r <= upd_any;
			end
			assign dac_code_o[ch*16 +: 16] = dac_r;
			assign dac_update_o[ch]        = upd_r;
		end
	endgenerate

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			int_ref_en_o <= 1'b0;
		else
			int_ref_en_o <= ref_en_r;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			shared_ref_pin_oe_o <= 1'b0;
		else
			shared_ref_pin_oe_o <= ref_en_r;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			clear_sel_o <= ODL_CLR_ZERO;
		else
			clear_sel_o <= clr_sel_r;
	end
endmodule // odl_core
`default_nettype wire

/* odl_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "odl_regs.svh"
module odl_props
	import odl_pkg::*;
(
	input wire logic                    clk_sys_i,
	input wire logic                    resetn_i,
	input wire logic                    sclk_i,
	input wire logic                    frame_sel_n_i,
	input wire logic                    sdata_i,
	input wire logic                    load_strobe_n_i,
	input wire logic                    async_clear_n_i,
	input wire logic [8*16-1:0]         dac_code_o,
	input wire logic [7:0]              dac_update_o,
	input wire logic                    int_ref_en_o,
	input wire logic                    shared_ref_pin_oe_o,
	input wire odl_pkg::odl_clr_sel_type clear_sel_o,
	input wire logic                    frame_drop_o
);
	// ----
	// Checks
	// ----
	wire logic [15:0] clr_code = (clear_sel_o == ODL_CLR_MID) ? `ODL_CODE_MID :
		(clear_sel_o == ODL_CLR_FULL) ? `ODL_CODE_FULL : `ODL_CODE_ZERO;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	property p_clr_default; $rose(resetn_i) |-> clear_sel_o == ODL_CLR_ZERO; endproperty
	a_clr_default: assert property (p_clr_default) else $error("clear code not zero");
	property p_ref_reset; $rose(resetn_i) |-> !int_ref_en_o && !shared_ref_pin_oe_o; endproperty
	a_ref_reset: assert property (p_ref_reset) else $error("ref not input");
	property p_ref_pin; !int_ref_en_o |-> !shared_ref_pin_oe_o; endproperty
	a_ref_pin: assert property (p_ref_pin) else $error("ref pin driven");
	property p_code_upd; $changed(dac_code_o) |-> dac_update_o != 8'h00; endproperty
	a_code_upd: assert property (p_code_upd) else $error("code moved silently");
	property p_clr_all; $fell(async_clear_n_i) |-> ##[1:6] dac_update_o == 8'hFF; endproperty
	a_clr_all: assert property (p_clr_all) else $error("clear missed");
	property p_clr_val;
		!async_clear_n_i && dac_update_o == 8'hFF |-> dac_code_o == {8{clr_code}};
	endproperty
	a_clr_val: assert property (p_clr_val) else $error("clear value wrong");
	property p_clr_block; !async_clear_n_i [*8] |-> dac_update_o == 8'h00; endproperty
	a_clr_block: assert property (p_clr_block) else $error("update under clear");
	// Quiet lines long enough for any answer to have landed
	property p_quiet;
		(frame_sel_n_i && load_strobe_n_i && async_clear_n_i) [*8] |=> $stable(dac_code_o);
	endproperty
	a_quiet: assert property (p_quiet) else $error("code moved while idle");
endmodule // odl_props
`default_nettype wire

/* odl_host.sv */
`timescale 1ns/10ps
`default_nettype none
module odl_host (
	output logic sclk_o,
	output logic frame_sel_n_o,
	output logic sdata_o
);
	// ----
	// Serial host
	// ----
	initial begin
		sclk_o = 1'b1;
		frame_sel_n_o = 1'b1;
		sdata_o = 1'b0;
	end
	// Clock stands high between frames; data line scrambled once released
	task automatic send(input logic [35:0] w, input int n);
		#3 frame_sel_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdata_o = w[35-i];
			#80 sclk_o = 1'b0;
			#80 sclk_o = 1'b1;
		end
		#80 frame_sel_n_o = 1'b1;
		sdata_o = ~sdata_o;
		#160;
	endtask
endmodule // odl_host
`default_nettype wire

/* odl_core_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "odl_regs.svh"
module odl_core_tb;
	import odl_pkg::*;
	logic clk_sys_i = 1'b0, resetn_i = 1'b1, load_strobe_n_i = 1'b1, async_clear_n_i = 1'b1;
	wire logic sclk_i, frame_sel_n_i, sdata_i;
	logic [127:0] dac_code_o;
	logic [7:0] dac_update_o, upd_acc = 8'h00;
	logic int_ref_en_o, shared_ref_pin_oe_o, frame_drop_o;
	odl_clr_sel_type clear_sel_o;
	int n_errors = 0, check_count = 0, n_pulse = 0, n_drop = 0;
	// ----
	// Harness
	// ----
	odl_core u_odl_core (.*);
	odl_host u_odl_host (.sclk_o(sclk_i), .frame_sel_n_o(frame_sel_n_i), .sdata_o(sdata_i));
	always #5 clk_sys_i = ~clk_sys_i;
	always @(negedge clk_sys_i) begin
		if (dac_update_o != 8'h00) begin
			upd_acc = upd_acc | dac_update_o;
			n_pulse++;
		end
		if (frame_drop_o === 1'b1) n_drop++;
	end
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	function automatic logic [35:0] mk(logic [3:0] c, logic [3:0] a, logic [15:0] d);
		return {4'h0, c, a, d, 8'h00};
	endfunction
	task automatic strobe();
		load_strobe_n_i = 1'b0;
		cyc(3);
		load_strobe_n_i = 1'b1;
		cyc(12);
	endtask
	task automatic complete_run();
		if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		chk("clr_sel", ODL_CLR_ZERO, clear_sel_o);
		chk("ref", 2'b00, {int_ref_en_o, shared_ref_pin_oe_o});
		chk("codes", 128'h0, dac_code_o);
	endtask
	task automatic t_write();
		upd_acc = 8'h00;
		u_odl_host.send(mk(4'h3, 4'h2, 16'h1234), 36);
		cyc(20);
		chk("ch2", 16'h1234, dac_code_o[47:32]);
		chk("upd", 8'h04, upd_acc);
	endtask
	task automatic t_abort();
		u_odl_host.send(mk(4'h3, 4'h2, 16'hBEEF), 20);
		cyc(20);
		chk("ch2_abort", 16'h1234, dac_code_o[47:32]);
		u_odl_host.send(mk(4'h3, 4'h2, 16'h0F0F), 32);
		cyc(20);
		chk("ch2_next", 16'h0F0F, dac_code_o[47:32]);
	endtask
	task automatic t_load();
		u_odl_host.send(mk(4'h0, 4'h4, 16'hAAAA), 32);
		u_odl_host.send(mk(4'h0, 4'h5, 16'h5555), 32);
		cyc(20);
		chk("ch4_held", 16'h0000, dac_code_o[79:64]);
		upd_acc = 8'h00;
		n_pulse = 0;
		strobe();
		chk("upd_set", 8'h30, upd_acc);
		chk("one_pulse", 1, n_pulse);
		chk("ch45", 32'h5555AAAA, dac_code_o[95:64]);
	endtask
	task automatic t_tied();
		load_strobe_n_i = 1'b0;
		u_odl_host.send(mk(4'h0, 4'h1, 16'hC3C3), 32);
		cyc(20);
		chk("ch1_tied", 16'hC3C3, dac_code_o[31:16]);
		load_strobe_n_i = 1'b1;
	endtask
	// Clear held low also stalls the buffer, so it fills and drops
	task automatic t_clear();
		u_odl_host.send(mk(4'h5, 4'h0, 16'h0000) | 36'h10, 32);
		cyc(20);
		chk("clr_mid", ODL_CLR_MID, clear_sel_o);
		async_clear_n_i = 1'b0;
		cyc(10);
		chk("clr_codes", {8{`ODL_CODE_MID}}, dac_code_o);
		upd_acc = 8'h00;
		for (int i = 0; i < 10; i++) u_odl_host.send(mk(4'h0, 4'h3, 16'h7777), 32);
		strobe();
		chk("no_xfer", 8'h00, upd_acc);
		chk("drops", 1, n_drop);
		async_clear_n_i = 1'b1;
		cyc(20);
		chk("ch3_kept", `ODL_CODE_MID, dac_code_o[63:48]);
	endtask
	task automatic t_ref();
		u_odl_host.send(mk(4'h8, 4'h0, 16'h0000) | 36'h10, 32);
		cyc(20);
		chk("ref_on", 2'b11, {int_ref_en_o, shared_ref_pin_oe_o});
	endtask
	initial begin
		#1;
		resetn_i = 1'b0;
		cyc(4);
		resetn_i = 1'b1;
		cyc(3);
		t_reset();
		t_write();
		t_abort();
		t_load();
		t_tied();
		t_clear();
		t_ref();
		complete_run();
	end
	initial begin
		#200000;
		n_errors++;
		complete_run();
	end
endmodule // odl_core_tb
bind odl_core odl_props u_odl_props (.*);
`default_nettype wire
